/* File: legacy_attr_pkg.sv */
// Constants, types and helpers for legacy region attribute steering
package legacy_attr_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam int          NUM_ATTR_REGS    = 7;
    localparam int          NUM_SEGMENTS     = 13;
    localparam logic [7:0]  TOP_ATTR_OFFSET  = 8'h90;
    localparam logic [7:0]  C0_ATTR_OFFSET   = 8'h91;
    localparam logic [7:0]  C8_ATTR_OFFSET   = 8'h92;
    localparam logic [7:0]  LAST_ATTR_OFFSET = 8'h96;
    localparam logic [2:0]  NO_ATTR_IDX      = 3'h7;
    localparam int          UPPER_FIELD_LSB  = 4;
    localparam int          LOWER_FIELD_LSB  = 0;
    localparam logic [7:0]  ATTR_RESET       = 8'h00;
    localparam logic [7:0]  PAIR_WRITE_MASK  = 8'h33;
    localparam logic [7:0]  TOP_WRITE_MASK   = 8'h30;

    // ************************************************************
    // Field encodings
    // ************************************************************
    localparam logic [1:0]  ATTR_SOUTH_ONLY  = 2'h0;
    localparam logic [1:0]  ATTR_READ_DRAM   = 2'h1;
    localparam logic [1:0]  ATTR_WRITE_DRAM  = 2'h2;
    localparam logic [1:0]  ATTR_FULL_DRAM   = 2'h3;
    localparam int          FETCH_CLAIM_POS  = 0;
    localparam int          WRITE_CLAIM_POS  = 1;

    // ************************************************************
    // Address windows
    // ************************************************************
    localparam logic [31:0] LEGACY_BASE      = 32'h000c0000;
    localparam logic [31:0] C4_SEG_BASE      = 32'h000c4000;
    localparam logic [31:0] C8_SEG_BASE      = 32'h000c8000;
    localparam logic [31:0] D0_SEG_BASE      = 32'h000d0000;
    localparam logic [31:0] TOP_SEG_BASE     = 32'h000f0000;
    localparam logic [31:0] LEGACY_LIMIT     = 32'h000fffff;
    localparam logic [4:0]  PAIR_SLOT_BIAS   = 5'h17;
    localparam logic [5:0]  SEG_SLOT_BIAS    = 6'h30;
    localparam logic [3:0]  TOP_SEG_NUM      = 4'hc;

    typedef struct packed {
        logic [NUM_ATTR_REGS-1:0][7:0] attr;
    } regfile_state_type;

    typedef struct packed {
        logic       cfg_ack;
        logic [7:0] cfg_rdata;
        logic       route_valid;
        logic       route_write;
        logic       route_pci;
        logic       route_legacy;
        logic       route_dram;
        logic       route_south;
        logic [1:0] route_field;
        logic [3:0] route_seg;
        logic       route_unsafe;
    } steer_state_type;

    function automatic logic [1:0] pick_field(input logic [7:0] attr, input logic upper);
        return upper ? attr[UPPER_FIELD_LSB +: 2] : attr[LOWER_FIELD_LSB +: 2];
    endfunction

    function automatic logic [7:0] write_mask(input logic [2:0] idx);
        return (idx == 3'h0) ? TOP_WRITE_MASK : PAIR_WRITE_MASK;
    endfunction

endpackage

/* File: attr_link_if.sv */
// Attribute bytes shared between the register store and the decoder
`timescale 1ns/1ps
`default_nettype none
interface attr_link_if;
    import legacy_attr_pkg::*;
    logic [NUM_ATTR_REGS-1:0][7:0] attr;
    modport store  (output attr);
    modport lookup (input attr);
endinterface
`default_nettype wire

/* File: attr_regfile.sv */
// Storage for the seven legacy region attribute bytes
`timescale 1ns/1ps
`default_nettype none
module attr_regfile
(
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        wr_en_i,
    input  wire logic [2:0]  wr_idx_i,
    input  wire logic [7:0]  wr_data_i,
    input  wire logic [2:0]  rd_idx_i,
    output logic      [7:0]  rd_data_o,
    attr_link_if.store       link
);
    import legacy_attr_pkg::*;

    regfile_state_type state_reg;
    regfile_state_type state_next;

    always_comb
    begin
        state_next = state_reg;
        if (wr_en_i && wr_idx_i != NO_ATTR_IDX)
        begin
            // Reserved bits never store anything
            state_next.attr[wr_idx_i] = wr_data_i & write_mask(wr_idx_i);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            state_reg.attr <= {NUM_ATTR_REGS{ATTR_RESET}};
        else
            state_reg <= state_next;
    end

    assign rd_data_o = (rd_idx_i == NO_ATTR_IDX) ? 8'h00 : state_reg.attr[rd_idx_i];
    assign link.attr = state_reg.attr;

endmodule // attr_regfile
`default_nettype wire

/* File: seg_decoder.sv */
// Maps an address onto its legacy segment and attribute field
`timescale 1ns/1ps
`default_nettype none
module seg_decoder
(
    input  wire logic [31:0] addr_i,
    attr_link_if.lookup      link,
    output logic             hit_o,
    output logic      [1:0]  field_o,
    output logic      [3:0]  seg_o
);
    import legacy_attr_pkg::*;

    logic [2:0] pair_idx;

    always_comb
    begin
        pair_idx = 3'(addr_i[19:15] - PAIR_SLOT_BIAS);
        hit_o    = 1'b0;
        field_o  = ATTR_SOUTH_ONLY;
        seg_o    = 4'h0;
        if (addr_i >= TOP_SEG_BASE && addr_i <= LEGACY_LIMIT)
        begin
            // One 64 KB segment, upper field only
            hit_o   = 1'b1;
            field_o = pick_field(link.attr[0], 1'b1);
            seg_o   = TOP_SEG_NUM;
        end
        else if (addr_i >= LEGACY_BASE && addr_i < TOP_SEG_BASE)
        begin
            // 16 KB segments, two to a byte, bit 14 picks the half
            hit_o   = 1'b1;
            field_o = pick_field(link.attr[pair_idx], addr_i[14]);
            seg_o   = 4'(addr_i[19:14] - SEG_SLOT_BIAS);
        end
    end

endmodule // seg_decoder
`default_nettype wire

/* File: legacy_bios_region_steering.sv */
// Top of the legacy region attribute decoder and its config port
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// ****************************************************************
module legacy_bios_region_steering
(
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        cfg_sel_i,
    input  wire logic        cfg_write_i,
    input  wire logic [7:0]  cfg_offset_i,
    input  wire logic [7:0]  cfg_wdata_i,
    output logic             cfg_ack_o,
    output logic      [7:0]  cfg_rdata_o,
    input  wire logic        mem_valid_i,
    input  wire logic        mem_write_i,
    input  wire logic        mem_pci_i,
    input  wire logic [31:0] mem_addr_i,
    output logic             route_valid_o,
    output logic             route_write_o,
    output logic             route_pci_o,
    output logic             route_legacy_o,
    output logic             route_dram_o,
    output logic             route_south_o,
    output logic      [1:0]  route_field_o,
    output logic      [3:0]  route_seg_o,
    output logic             route_unsafe_o
);
    import legacy_attr_pkg::*;

    // ************************************************************
    // Configuration port
    // ************************************************************
    attr_link_if link ();

    logic [2:0] cfg_idx;
    logic [7:0] rd_byte;
    logic       dec_hit;
    logic [1:0] dec_field;
    logic [3:0] dec_seg;
    logic       fetch_claim;
    logic       write_claim;
    logic       claim;

    // Offsets outside the seven bytes read zero and drop writes
    always_comb
    begin
        if (cfg_offset_i >= TOP_ATTR_OFFSET && cfg_offset_i <= LAST_ATTR_OFFSET)
            cfg_idx = 3'(cfg_offset_i - TOP_ATTR_OFFSET);
        else
            cfg_idx = NO_ATTR_IDX;
    end

    attr_regfile u_regfile
    (
        .clk_i     (clk_i),
        .rst_b_i   (rst_b_i),
        .wr_en_i   (cfg_sel_i && cfg_write_i),
        .wr_idx_i  (cfg_idx),
        .wr_data_i (cfg_wdata_i),
        .rd_idx_i  (cfg_idx),
        .rd_data_o (rd_byte),
        .link      (link.store)
    );

    // ************************************************************
    // Segment decode
    // ************************************************************
    seg_decoder u_decoder
    (
        .addr_i  (mem_addr_i),
        .link    (link.lookup),
        .hit_o   (dec_hit),
        .field_o (dec_field),
        .seg_o   (dec_seg)
    );

    assign fetch_claim = dec_field[FETCH_CLAIM_POS];
    assign write_claim = dec_field[WRITE_CLAIM_POS];
    // Origin plays no part in the claim decision
    assign claim = mem_write_i ? write_claim : fetch_claim;

    // ************************************************************
    // State
    // ************************************************************
    steer_state_type state_reg;
    steer_state_type state_next;

    always_comb
    begin
        state_next              = state_reg;
        state_next.cfg_ack      = cfg_sel_i;
        state_next.route_valid  = mem_valid_i;
        if (cfg_sel_i)
        begin
            // Writes answer with the old byte, reads with the stored one
            state_next.cfg_rdata = rd_byte;
        end
        if (mem_valid_i)
        begin
            state_next.route_write  = mem_write_i;
            state_next.route_pci    = mem_pci_i;
            state_next.route_legacy = dec_hit;
            state_next.route_field  = dec_field;
            state_next.route_seg    = dec_seg;
            // Addresses outside the window are left to other decoders
            state_next.route_dram   = dec_hit && claim;
            state_next.route_south  = dec_hit && !claim;
            // Flags a PCI-origin legacy access whose field is not full DRAM, even one routed to DRAM
            state_next.route_unsafe = dec_hit && mem_pci_i
                                      && (dec_field != ATTR_FULL_DRAM);
        end
        else
        begin
            state_next.route_dram   = 1'b0;
            state_next.route_south  = 1'b0;
            state_next.route_unsafe = 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign cfg_ack_o      = state_reg.cfg_ack;
    assign cfg_rdata_o    = state_reg.cfg_rdata;
    assign route_valid_o  = state_reg.route_valid;
    assign route_write_o  = state_reg.route_write;
    assign route_pci_o    = state_reg.route_pci;
    assign route_legacy_o = state_reg.route_legacy;
    assign route_dram_o   = state_reg.route_dram;
    assign route_south_o  = state_reg.route_south;
    assign route_field_o  = state_reg.route_field;
    assign route_seg_o    = state_reg.route_seg;
    assign route_unsafe_o = state_reg.route_unsafe;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    chk_segment_span: assert property (
        dec_hit |-> dec_seg < 4'(NUM_SEGMENTS)
    ) else $error("segment number out of range");

    chk_seventh_byte: assert property (
        cfg_sel_i && cfg_write_i && cfg_offset_i == LAST_ATTR_OFFSET
        |=> link.attr[6] == ($past(cfg_wdata_i) & PAIR_WRITE_MASK)
    ) else $error("last attribute byte not written");

    chk_origin_blind: assert property (
        mem_valid_i
        |=> route_pci_o == $past(mem_pci_i)
            && route_field_o == $past(dec_field)
            && route_dram_o == ($past(dec_hit) && $past(claim))
    ) else $error("origin changed the routing");

    chk_read_steer: assert property (
        mem_valid_i && !mem_write_i && dec_hit
        |=> route_valid_o && route_dram_o == $past(fetch_claim)
            && route_south_o == !route_dram_o
    ) else $error("read not steered by read claim");

    chk_write_steer: assert property (
        mem_valid_i && mem_write_i && dec_hit
        |=> route_valid_o && route_dram_o == $past(write_claim)
            && route_south_o == !route_dram_o
    ) else $error("write not steered by write claim");

    chk_all_south: assert property (
        mem_valid_i && dec_hit && dec_field == ATTR_SOUTH_ONLY
        |=> route_south_o && !route_dram_o
    ) else $error("disabled segment reached memory");

    chk_read_only: assert property (
        mem_valid_i && dec_hit && dec_field == ATTR_READ_DRAM
        |=> route_dram_o == !route_write_o && route_south_o == route_write_o
    ) else $error("read-only segment misrouted");

    chk_write_only: assert property (
        mem_valid_i && dec_hit && dec_field == ATTR_WRITE_DRAM
        |=> route_dram_o == route_write_o && route_south_o == !route_write_o
    ) else $error("write-only segment misrouted");

    chk_full_memory: assert property (
        mem_valid_i && dec_hit && dec_field == ATTR_FULL_DRAM
        |=> route_dram_o && !route_south_o
    ) else $error("enabled segment went south");

    chk_top_segment: assert property (
        mem_valid_i && mem_addr_i >= TOP_SEG_BASE && mem_addr_i <= LEGACY_LIMIT
        |=> route_seg_o == TOP_SEG_NUM
            && route_field_o == pick_field($past(link.attr[0]), 1'b1)
    ) else $error("top segment not using upper field of 90h");

    chk_c0_upper: assert property (
        mem_valid_i && mem_addr_i >= C4_SEG_BASE && mem_addr_i < C8_SEG_BASE
        |=> route_field_o == pick_field($past(link.attr[1]), 1'b1)
    ) else $error("0C4000h segment wrong field");

    chk_c0_lower: assert property (
        mem_valid_i && mem_addr_i >= LEGACY_BASE && mem_addr_i < C4_SEG_BASE
        |=> route_field_o == pick_field($past(link.attr[1]), 1'b0)
    ) else $error("0C0000h segment wrong field");

    chk_c8_pair: assert property (
        mem_valid_i && mem_addr_i >= C8_SEG_BASE && mem_addr_i < D0_SEG_BASE
        |=> route_field_o == pick_field($past(link.attr[2]), $past(mem_addr_i[14]))
    ) else $error("0C8000h pair wrong field");

    chk_reset_south: assert property (
        $past(!rst_b_i) |-> link.attr == '0 && !route_valid_o && !cfg_ack_o
    ) else $error("fields not cleared by reset");

    chk_reserved_zero: assert property (
        cfg_sel_i && !cfg_write_i && cfg_idx != NO_ATTR_IDX
        |=> cfg_ack_o && (cfg_rdata_o & ~write_mask($past(cfg_idx))) == 8'h00
    ) else $error("reserved bits read nonzero");

    chk_outside_quiet: assert property (
        mem_valid_i && !dec_hit
        |=> !route_legacy_o ##0 !route_dram_o && !route_south_o
    ) else $error("access outside legacy range was steered");

    chk_unsafe_flag: assert property (
        mem_valid_i && dec_hit && mem_pci_i && dec_field != ATTR_FULL_DRAM
        |=> route_unsafe_o
    ) else $error("hazardous access not flagged");

    // ************************************************************
    // Handshake and hold checks
    // ************************************************************
    // Every config access is answered, idle cycles stay silent
    chk_ack_pulse: assert property (
        cfg_sel_i |=> cfg_ack_o
    ) else $error("config access not acknowledged");

    chk_ack_idle: assert property (
        !cfg_sel_i |=> !cfg_ack_o
    ) else $error("acknowledge without access");

    chk_rdata_hold: assert property (
        !cfg_sel_i |=> $stable(cfg_rdata_o)
    ) else $error("read data moved without access");

    chk_unmapped_read: assert property (
        cfg_sel_i && cfg_idx == NO_ATTR_IDX |=> cfg_rdata_o == 8'h00
    ) else $error("unmapped offset read nonzero");

    chk_unmapped_drop: assert property (
        cfg_sel_i && cfg_write_i && cfg_idx == NO_ATTR_IDX |=> $stable(link.attr)
    ) else $error("unmapped write changed a field");

    chk_write_masked: assert property (
        cfg_sel_i && cfg_write_i && cfg_idx != NO_ATTR_IDX
        |=> (link.attr[$past(cfg_idx)] & ~write_mask($past(cfg_idx))) == 8'h00
    ) else $error("reserved bit stored");

    chk_route_idle: assert property (
        !mem_valid_i
        |=> !route_valid_o && !route_dram_o && !route_south_o && !route_unsafe_o
    ) else $error("route strobe without request");

    chk_route_hold: assert property (
        !mem_valid_i
        |=> $stable(route_field_o) && $stable(route_seg_o) && $stable(route_legacy_o)
    ) else $error("route status moved without request");

    chk_legacy_flag: assert property (
        mem_valid_i
        |=> route_legacy_o == ($past(mem_addr_i) >= LEGACY_BASE
                               && $past(mem_addr_i) <= LEGACY_LIMIT)
    ) else $error("legacy window flag wrong");

    chk_write_echo: assert property (
        mem_valid_i |=> route_write_o == $past(mem_write_i)
    ) else $error("access direction not echoed");

    chk_host_safe: assert property (
        mem_valid_i && !mem_pci_i |=> !route_unsafe_o
    ) else $error("host access flagged hazardous");

    cov_write_dram: cover property (
        route_valid_o && route_write_o && route_dram_o
    );

    cov_read_south: cover property (
        route_valid_o && !route_write_o && route_south_o
    );

    cov_top_hit: cover property (
        route_valid_o && route_seg_o == TOP_SEG_NUM && route_dram_o
    );

    cov_unsafe_seen: cover property (
        route_valid_o && route_unsafe_o
    );

    cov_program_then_use: cover property (
        cfg_sel_i && cfg_write_i ##1 mem_valid_i && dec_hit ##1 route_dram_o
    );

endmodule // legacy_bios_region_steering
`default_nettype wire

/* File: mem_initiator.sv */
// Memory cycle initiator standing in for the host and PCI masters
`timescale 1ns/1ps
`default_nettype none
module mem_initiator
(
    input  wire logic        clk_i,
    output logic             mem_valid_o,
    output logic             mem_write_o,
    output logic             mem_pci_o,
    output logic      [31:0] mem_addr_o
);
    initial
    begin
        mem_valid_o = 1'b0;
        mem_write_o = 1'b0;
        mem_pci_o   = 1'b0;
        mem_addr_o  = 32'h00000000;
    end

    // One cycle per request, launched just after an edge
    task automatic issue(input logic wr, input logic pci, input logic [31:0] addr);
        @(posedge clk_i);
        #1;
        mem_valid_o = 1'b1;
        mem_write_o = wr;
        mem_pci_o   = pci;
        mem_addr_o  = addr;
        @(posedge clk_i);
        #1;
        mem_valid_o = 1'b0;
        // Released lines flip so a stale value is never mistaken for live
        mem_write_o = ~wr;
        mem_pci_o   = ~pci;
        mem_addr_o  = ~addr;
    endtask
endmodule // mem_initiator
`default_nettype wire

/* File: tb_legacy_bios_region_steering.sv */
// Self-checking bench for the legacy region attribute decoder
`timescale 1ns/1ps
`default_nettype none
module tb_legacy_bios_region_steering;
    import legacy_attr_pkg::*;

    typedef struct packed {
        logic [7:0]  off;
        logic [7:0]  data;
        logic        wr;
        logic        pci;
        logic [31:0] addr;
        logic        dram;
        logic [1:0]  field;
        logic [3:0]  seg;
    } row_type;

    logic        clk_i;
    logic        rst_b_i;
    logic        cfg_sel_i;
    logic        cfg_write_i;
    logic [7:0]  cfg_offset_i;
    logic [7:0]  cfg_wdata_i;
    logic        cfg_ack_o;
    logic [7:0]  cfg_rdata_o;
    logic        mem_valid_i;
    logic        mem_write_i;
    logic        mem_pci_i;
    logic [31:0] mem_addr_i;
    logic        route_valid_o;
    logic        route_write_o;
    logic        route_pci_o;
    logic        route_legacy_o;
    logic        route_dram_o;
    logic        route_south_o;
    logic [1:0]  route_field_o;
    logic [3:0]  route_seg_o;
    logic        route_unsafe_o;
    logic [7:0]  rd;
    int          n_errors;
    int          checks;

    // ************************************************************
    // Ordinary cases: program a field, then hit its segment
    // ************************************************************
    localparam row_type ROWS [9] = '{
        '{8'h91, 8'h01, 1'b0, 1'b0, 32'h000c0010, 1'b1, 2'h1, 4'h0},
        '{8'h91, 8'h01, 1'b1, 1'b1, 32'h000c3fff, 1'b0, 2'h1, 4'h0},
        '{8'h91, 8'h20, 1'b0, 1'b0, 32'h000c4000, 1'b0, 2'h2, 4'h1},
        '{8'h91, 8'h20, 1'b1, 1'b0, 32'h000c7fff, 1'b1, 2'h2, 4'h1},
        '{8'h92, 8'h03, 1'b0, 1'b1, 32'h000c8000, 1'b1, 2'h3, 4'h2},
        '{8'h92, 8'h30, 1'b1, 1'b0, 32'h000cffff, 1'b1, 2'h3, 4'h3},
        '{8'h90, 8'h10, 1'b0, 1'b0, 32'h000f0000, 1'b1, 2'h1, 4'hc},
        '{8'h90, 8'h10, 1'b1, 1'b0, 32'h000fffff, 1'b0, 2'h1, 4'hc},
        '{8'h90, 8'h00, 1'b0, 1'b1, 32'h000f8000, 1'b0, 2'h0, 4'hc}
    };

    legacy_bios_region_steering uut
    (
        .clk_i          (clk_i),
        .rst_b_i        (rst_b_i),
        .cfg_sel_i      (cfg_sel_i),
        .cfg_write_i    (cfg_write_i),
        .cfg_offset_i   (cfg_offset_i),
        .cfg_wdata_i    (cfg_wdata_i),
        .cfg_ack_o      (cfg_ack_o),
        .cfg_rdata_o    (cfg_rdata_o),
        .mem_valid_i    (mem_valid_i),
        .mem_write_i    (mem_write_i),
        .mem_pci_i      (mem_pci_i),
        .mem_addr_i     (mem_addr_i),
        .route_valid_o  (route_valid_o),
        .route_write_o  (route_write_o),
        .route_pci_o    (route_pci_o),
        .route_legacy_o (route_legacy_o),
        .route_dram_o   (route_dram_o),
        .route_south_o  (route_south_o),
        .route_field_o  (route_field_o),
        .route_seg_o    (route_seg_o),
        .route_unsafe_o (route_unsafe_o)
    );

    mem_initiator u_init
    (
        .clk_i       (clk_i),
        .mem_valid_o (mem_valid_i),
        .mem_write_o (mem_write_i),
        .mem_pci_o   (mem_pci_i),
        .mem_addr_o  (mem_addr_i)
    );

    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic do_reset();
        @(posedge clk_i);
        #1;
        rst_b_i = 1'b0;
        repeat (6) @(posedge clk_i);
        #1;
        rst_b_i = 1'b1;
    endtask

    // Single config byte access; ack is due exactly one cycle after sel
    task automatic cfg(input logic wr, input logic [7:0] off, input logic [7:0] wd,
                       output logic [7:0] rdata);
        @(posedge clk_i);
        #1;
        cfg_sel_i    = 1'b1;
        cfg_write_i  = wr;
        cfg_offset_i = off;
        cfg_wdata_i  = wd;
        @(posedge clk_i);
        #1;
        cfg_sel_i    = 1'b0;
        cfg_write_i  = ~wr;
        cfg_offset_i = ~off;
        cfg_wdata_i  = ~wd;
        chk(cfg_ack_o, 1'b1, "cfg ack");
        rdata = cfg_rdata_o;
    endtask

    task automatic mem(input logic wr, input logic pci, input logic [31:0] addr,
                       input logic lg, input logic dr, input logic [1:0] fld,
                       input logic [3:0] sg);
        u_init.issue(wr, pci, addr);
        chk(route_valid_o, 1'b1, "route valid");
        chk(route_write_o, wr, "write echo");
        chk(route_pci_o, pci, "origin echo");
        chk(route_legacy_o, lg, "legacy hit");
        chk(route_dram_o, dr, "dram claim");
        chk(route_south_o, lg & ~dr, "south forward");
        chk(route_unsafe_o, lg & pci & (fld != ATTR_FULL_DRAM), "unsafe flag");
        if (lg)
        begin
            chk(route_field_o, fld, "field");
            chk(route_seg_o, sg, "segment");
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        n_errors     = 0;
        checks       = 0;
        rst_b_i      = 1'b0;
        cfg_sel_i    = 1'b0;
        cfg_write_i  = 1'b0;
        cfg_offset_i = 8'h00;
        cfg_wdata_i  = 8'h00;
        do_reset();
        chk(cfg_ack_o, 1'b0, "ack idle");
        chk(route_valid_o, 1'b0, "route idle");

        // ********************************************************
        // Reset values and the disabled encoding after reset
        // ********************************************************
        for (int o = 8'h90; o <= 8'h96; o++)
        begin
            cfg(1'b0, o[7:0], 8'h00, rd);
            chk(rd, ATTR_RESET, "reset byte");
        end
        mem(1'b0, 1'b0, 32'h000f0000, 1'b1, 1'b0, 2'h0, 4'hc);
        $display("test reset values done");

        // ********************************************************
        // Table of field codes and segment windows
        // ********************************************************
        foreach (ROWS[i])
        begin
            cfg(1'b1, ROWS[i].off, ROWS[i].data, rd);
            mem(ROWS[i].wr, ROWS[i].pci, ROWS[i].addr, 1'b1, ROWS[i].dram,
                ROWS[i].field, ROWS[i].seg);
        end
        $display("test field table done");

        // ********************************************************
        // Reserved bits, unmapped offset, out-of-range addresses
        // ********************************************************
        cfg(1'b1, 8'h90, 8'hff, rd);
        cfg(1'b0, 8'h90, 8'h00, rd);
        chk(rd, 8'h30, "top reserved");
        cfg(1'b1, 8'h91, 8'hff, rd);
        cfg(1'b0, 8'h91, 8'h00, rd);
        chk(rd, 8'h33, "pair reserved");
        cfg(1'b1, 8'h96, 8'hff, rd);
        cfg(1'b0, 8'h96, 8'h00, rd);
        chk(rd, 8'h33, "last byte");
        cfg(1'b1, 8'h97, 8'hff, rd);
        cfg(1'b0, 8'h97, 8'h00, rd);
        chk(rd, 8'h00, "unmapped byte");
        mem(1'b0, 1'b0, 32'h000bffff, 1'b0, 1'b0, 2'h0, 4'h0);
        mem(1'b1, 1'b1, 32'h00100000, 1'b0, 1'b0, 2'h0, 4'h0);
        $display("test reserved and range done");

        // ********************************************************
        // Reset in mid-run clears programmed fields
        // ********************************************************
        do_reset();
        cfg(1'b0, 8'h91, 8'h00, rd);
        chk(rd, 8'h00, "byte after reset");
        mem(1'b1, 1'b0, 32'h000c0000, 1'b1, 1'b0, 2'h0, 4'h0);
        $display("test mid-run reset done");
        final_report();
    end
endmodule // tb_legacy_bios_region_steering
`default_nettype wire
